// File: logic/overheat_qualifier.v
// qualifies one over-temperature fault with a delay timer and a release temperature
`timescale 1ns/1ps
`default_nettype none
`include "pack_temp_map.vh"
module overheat_qualifier (
  // clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // measurement
  input  wire                   tick,
  input  wire                   direction_active,
  input  wire [15:0]            temperature,
  // configuration
  input  wire [15:0]            threshold,
  input  wire [15:0]            release_temp,
  input  wire [`DELAY_W-1:0]    delay,
  // result
  output reg                    flag,
  output reg                    set_event
);
  reg [`DELAY_W-1:0] timer;
  wire hot     = direction_active && ($signed(temperature) >= $signed(threshold));
  wire cooled  = $signed(temperature) <= $signed(release_temp);

  always @(posedge aclk) begin
    if (!aresetn) begin
      flag      <= 1'b0;
      timer     <= {`DELAY_W{1'b0}};
      set_event <= 1'b0;
    end else begin
      set_event <= 1'b0;
      if (tick) begin
        if (flag) begin
          timer <= {`DELAY_W{1'b0}};
          if (cooled)
            flag <= 1'b0;
        end else if (delay == {`DELAY_W{1'b0}}) begin
          timer <= {`DELAY_W{1'b0}};
        end else if (hot) begin
          // flag sets once the condition has held for the full delay in seconds
          if (timer == delay) begin
            flag      <= 1'b1;
            set_event <= 1'b1;
            timer     <= {`DELAY_W{1'b0}};
          end else begin
            timer <= timer + 1'b1;
          end
        end else begin
          timer <= {`DELAY_W{1'b0}};
        end
      end
    end
  end
endmodule // overheat_qualifier
`default_nettype wire

// File: logic/pack_temp_map.vh
// register map, field positions, reset values and timing for the pack temperature protection block
`ifndef PACK_TEMP_MAP_VH
`define PACK_TEMP_MAP_VH
// register byte offsets
`define REG_CONTROL          6'h00
`define REG_STATUS           6'h04
`define REG_INT_STATUS       6'h08
`define REG_INT_MASK         6'h0c
`define REG_CHG_CURRENT_THR  6'h10
`define REG_DSG_CURRENT_THR  6'h14
`define REG_CHG_OH_THR       6'h18
`define REG_CHG_OH_DELAY     6'h1c
`define REG_CHG_OH_RELEASE   6'h20
`define REG_DSG_OH_THR       6'h24
`define REG_DSG_OH_DELAY     6'h28
`define REG_DSG_OH_RELEASE   6'h2c
`define REG_BLOCK_LOW        6'h30
`define REG_BLOCK_HIGH       6'h34
`define REG_BLOCK_HYS        6'h38
`define REG_TEMPERATURE      6'h3c
// field positions
`define CTRL_BLOCK_EN_BIT    0
`define EVT_CHG_OH_BIT       0
`define EVT_DSG_OH_BIT       1
`define EVT_BLOCK_BIT        2
`define EVT_W                3
`define DELAY_W              8
// reset values, temperatures in signed 0.1 degC, currents in signed mA
`define RST_CHG_CURRENT_THR  16'h0032
`define RST_DSG_CURRENT_THR  16'h0032
`define RST_CHG_OH_THR       16'h0226
`define RST_CHG_OH_DELAY     8'h02
`define RST_CHG_OH_RELEASE   16'h01f4
`define RST_DSG_OH_THR       16'h0258
`define RST_DSG_OH_DELAY     8'h02
`define RST_DSG_OH_RELEASE   16'h0226
`define RST_BLOCK_LOW        16'h0000
`define RST_BLOCK_HIGH       16'h01c2
`define RST_BLOCK_HYS        16'h0064
// axi responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10
// timebase
`define CLK_PERIOD_NS        50
`define TICK_PERIOD_NS       1000000000
`define TICK_CNT_W           25
`endif

// File: logic/pack_temp_protect.v
// pack temperature protection with axi4-lite registers and interrupt
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pack_temp_map.vh"
module pack_temp_protect #(
  parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // axi4-lite write address
  input  wire [31:0]            s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // axi4-lite read address
  input  wire [31:0]            s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // measurements, same clock domain
  input  wire [15:0]            temperature,
  input  wire [15:0]            current,
  // charger control and interrupt
  output reg                    battery_good_n,
  output reg                    irq
);
  // write-side byte lane merge for the 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // true when the word address names a register
  function mapped;
    input [5:0] a;
    begin
      mapped = (a <= `REG_TEMPERATURE);
    end
  endfunction

  // configuration registers
  reg                    charge_block_enable;
  reg [`EVT_W-1:0]       int_status;
  reg [`EVT_W-1:0]       int_mask;
  reg [15:0]             chg_current_thr;
  reg [15:0]             dsg_current_thr;
  reg [15:0]             charge_overheat_threshold;
  reg [`DELAY_W-1:0]     charge_overheat_delay;
  reg [15:0]             charge_overheat_release_temp;
  reg [15:0]             discharge_overheat_threshold;
  reg [`DELAY_W-1:0]     discharge_overheat_delay;
  reg [15:0]             discharge_overheat_release_temp;
  reg [15:0]             block_low;
  reg [15:0]             block_high;
  reg [15:0]             block_hys;
  reg [15:0]             last_temperature;

  // block state
  reg                    charge_block_flag;
  reg                    block_set_event;
  wire                   charge_overheat_flag;
  wire                   discharge_overheat_flag;
  wire                   chg_oh_event;
  wire                   dsg_oh_event;
  wire                   tick;

  // bus state
  reg                    aw_held;
  reg                    w_held;
  reg [5:0]              aw_addr;
  reg                    aw_err;
  reg [31:0]             w_data;
  reg [3:0]              w_strb;
  reg [31:0]             next_rdata;
  reg                    addr_ok;

  // direction and window decisions, 17 bits so the negated threshold never wraps
  wire signed [16:0] temp_s   = {temperature[15], temperature};
  wire signed [16:0] cur_s    = {current[15], current};
  wire signed [16:0] chg_th_s = {chg_current_thr[15], chg_current_thr};
  wire signed [16:0] dsg_th_s = {dsg_current_thr[15], dsg_current_thr};
  wire signed [16:0] low_s    = {block_low[15], block_low};
  wire signed [16:0] high_s   = {block_high[15], block_high};
  wire signed [16:0] hys_s    = {block_hys[15], block_hys};
  wire               charging    = cur_s > chg_th_s;
  wire               discharging = cur_s < -dsg_th_s;
  wire               too_cold    = temp_s <= low_s;
  wire               too_hot     = temp_s >= high_s;
  wire               back_inside = (temp_s >= low_s + hys_s) && (temp_s <= high_s - hys_s);
  wire               do_write    = aw_held && w_held && !s_axi_bvalid;
  // an unmapped address must not alias onto a register through its low bits
  wire               write_ok    = do_write && !aw_err;

  // timebase for all threshold checks
  second_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  overheat_qualifier u_chg_oh (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .tick             (tick),
    .direction_active (charging),
    .temperature      (temperature),
    .threshold        (charge_overheat_threshold),
    .release_temp     (charge_overheat_release_temp),
    .delay            (charge_overheat_delay),
    .flag             (charge_overheat_flag),
    .set_event        (chg_oh_event)
  );

  overheat_qualifier u_dsg_oh (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .tick             (tick),
    .direction_active (discharging),
    .temperature      (temperature),
    .threshold        (discharge_overheat_threshold),
    .release_temp     (discharge_overheat_release_temp),
    .delay            (discharge_overheat_delay),
    .flag             (discharge_overheat_flag),
    .set_event        (dsg_oh_event)
  );

  // charge inhibit with hysteresis; the charger line acts on any current,
  // the flag only records an out-of-range sample seen while charging
  always @(posedge aclk) begin
    if (!aresetn) begin
      battery_good_n    <= 1'b0;
      charge_block_flag <= 1'b0;
      block_set_event   <= 1'b0;
      last_temperature  <= 16'h0000;
    end else begin
      block_set_event <= 1'b0;
      if (tick) begin
        last_temperature <= temperature;
        if (!charge_block_enable) begin
          battery_good_n    <= 1'b0;
          charge_block_flag <= 1'b0;
        end else if (battery_good_n || charge_block_flag) begin
          if (back_inside) begin
            battery_good_n    <= 1'b0;
            charge_block_flag <= 1'b0;
          end else if (!charge_block_flag && charging) begin
            charge_block_flag <= 1'b1;
            block_set_event   <= 1'b1;
          end
        end else if (too_cold || too_hot) begin
          battery_good_n <= 1'b1;
          if (charging) begin
            charge_block_flag <= 1'b1;
            block_set_event   <= 1'b1;
          end
        end
      end
    end
  end

  // interrupt: a new event wins over a write-one-to-clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= {`EVT_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      int_status <= (int_status & ~((write_ok && aw_addr == `REG_INT_STATUS && w_strb[0]) ?
                                     w_data[`EVT_W-1:0] : {`EVT_W{1'b0}}))
                    | {block_set_event, dsg_oh_event, chg_oh_event};
      irq        <= |(int_status & int_mask);
    end
  end

  // write channel: address and data are taken independently, in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 6'h00;
      aw_err       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[5:2], 2'b00};
        aw_err  <= (s_axi_awaddr[31:6] != 26'h0000000);
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (mapped(aw_addr) && !aw_err) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      charge_block_enable             <= 1'b0;
      int_mask                        <= {`EVT_W{1'b0}};
      chg_current_thr                 <= `RST_CHG_CURRENT_THR;
      dsg_current_thr                 <= `RST_DSG_CURRENT_THR;
      charge_overheat_threshold       <= `RST_CHG_OH_THR;
      charge_overheat_delay           <= `RST_CHG_OH_DELAY;
      charge_overheat_release_temp    <= `RST_CHG_OH_RELEASE;
      discharge_overheat_threshold    <= `RST_DSG_OH_THR;
      discharge_overheat_delay        <= `RST_DSG_OH_DELAY;
      discharge_overheat_release_temp <= `RST_DSG_OH_RELEASE;
      block_low                       <= `RST_BLOCK_LOW;
      block_high                      <= `RST_BLOCK_HIGH;
      block_hys                       <= `RST_BLOCK_HYS;
    end else if (write_ok) begin
      if (aw_addr == `REG_CONTROL) begin
        if (w_strb[0])
          charge_block_enable <= w_data[`CTRL_BLOCK_EN_BIT];
      end else if (aw_addr == `REG_INT_MASK) begin
        if (w_strb[0])
          int_mask <= w_data[`EVT_W-1:0];
      end else if (aw_addr == `REG_CHG_CURRENT_THR) begin
        chg_current_thr <= merge16(chg_current_thr, w_data, w_strb);
      end else if (aw_addr == `REG_DSG_CURRENT_THR) begin
        dsg_current_thr <= merge16(dsg_current_thr, w_data, w_strb);
      end else if (aw_addr == `REG_CHG_OH_THR) begin
        charge_overheat_threshold <= merge16(charge_overheat_threshold, w_data, w_strb);
      end else if (aw_addr == `REG_CHG_OH_DELAY) begin
        if (w_strb[0])
          charge_overheat_delay <= w_data[`DELAY_W-1:0];
      end else if (aw_addr == `REG_CHG_OH_RELEASE) begin
        charge_overheat_release_temp <= merge16(charge_overheat_release_temp, w_data, w_strb);
      end else if (aw_addr == `REG_DSG_OH_THR) begin
        discharge_overheat_threshold <= merge16(discharge_overheat_threshold, w_data, w_strb);
      end else if (aw_addr == `REG_DSG_OH_DELAY) begin
        if (w_strb[0])
          discharge_overheat_delay <= w_data[`DELAY_W-1:0];
      end else if (aw_addr == `REG_DSG_OH_RELEASE) begin
        discharge_overheat_release_temp <= merge16(discharge_overheat_release_temp, w_data, w_strb);
      end else if (aw_addr == `REG_BLOCK_LOW) begin
        block_low <= merge16(block_low, w_data, w_strb);
      end else if (aw_addr == `REG_BLOCK_HIGH) begin
        block_high <= merge16(block_high, w_data, w_strb);
      end else if (aw_addr == `REG_BLOCK_HYS) begin
        block_hys <= merge16(block_hys, w_data, w_strb);
      end
    end
  end

  // read decode; status and temperature are read-only
  always @* begin
    next_rdata = 32'h00000000;
    addr_ok    = (s_axi_araddr[31:6] == 26'h0000000);
    if (s_axi_araddr[5:0] == `REG_CONTROL) begin
      next_rdata[`CTRL_BLOCK_EN_BIT] = charge_block_enable;
    end else if (s_axi_araddr[5:0] == `REG_STATUS) begin
      next_rdata[3:0] = {battery_good_n, charge_block_flag, discharge_overheat_flag, charge_overheat_flag};
    end else if (s_axi_araddr[5:0] == `REG_INT_STATUS) begin
      next_rdata[`EVT_W-1:0] = int_status;
    end else if (s_axi_araddr[5:0] == `REG_INT_MASK) begin
      next_rdata[`EVT_W-1:0] = int_mask;
    end else if (s_axi_araddr[5:0] == `REG_CHG_CURRENT_THR) begin
      next_rdata[15:0] = chg_current_thr;
    end else if (s_axi_araddr[5:0] == `REG_DSG_CURRENT_THR) begin
      next_rdata[15:0] = dsg_current_thr;
    end else if (s_axi_araddr[5:0] == `REG_CHG_OH_THR) begin
      next_rdata[15:0] = charge_overheat_threshold;
    end else if (s_axi_araddr[5:0] == `REG_CHG_OH_DELAY) begin
      next_rdata[`DELAY_W-1:0] = charge_overheat_delay;
    end else if (s_axi_araddr[5:0] == `REG_CHG_OH_RELEASE) begin
      next_rdata[15:0] = charge_overheat_release_temp;
    end else if (s_axi_araddr[5:0] == `REG_DSG_OH_THR) begin
      next_rdata[15:0] = discharge_overheat_threshold;
    end else if (s_axi_araddr[5:0] == `REG_DSG_OH_DELAY) begin
      next_rdata[`DELAY_W-1:0] = discharge_overheat_delay;
    end else if (s_axi_araddr[5:0] == `REG_DSG_OH_RELEASE) begin
      next_rdata[15:0] = discharge_overheat_release_temp;
    end else if (s_axi_araddr[5:0] == `REG_BLOCK_LOW) begin
      next_rdata[15:0] = block_low;
    end else if (s_axi_araddr[5:0] == `REG_BLOCK_HIGH) begin
      next_rdata[15:0] = block_high;
    end else if (s_axi_araddr[5:0] == `REG_BLOCK_HYS) begin
      next_rdata[15:0] = block_hys;
    end else if (s_axi_araddr[5:0] == `REG_TEMPERATURE) begin
      next_rdata[15:0] = last_temperature;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // read channel: one read at a time, answered the cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= addr_ok ? next_rdata : 32'h00000000;
      s_axi_rresp  <= addr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pack_temp_protect
`default_nettype wire

// File: logic/second_tick.v
// one-cycle pulse once per measurement period
`timescale 1ns/1ps
`default_nettype none
`include "pack_temp_map.vh"
module second_tick #(
  parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // timebase
  output reg                    tick
);
  reg [`TICK_CNT_W-1:0] count;
  wire [31:0]            last_full = TICK_CYCLES - 1;
  wire [`TICK_CNT_W-1:0] last      = last_full[`TICK_CNT_W-1:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= {`TICK_CNT_W{1'b0}};
      tick  <= 1'b0;
    end else if (count == last) begin
      count <= {`TICK_CNT_W{1'b0}};
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule // second_tick
`default_nettype wire

// File: tb/charger_model.sv
// charger model: charges only while battery good is asserted low
`timescale 1ns/1ps
`default_nettype none
module charger_model (
  // clock
  input  wire logic        aclk,
  // charger demand and system load
  input  wire logic        battery_good_n,
  input  wire logic        want_charge,
  input  wire logic [15:0] load_ma,
  // measured pack current, positive while charging
  output var  logic [15:0] current
);
  initial current = 16'h0000;
  // one cycle late, as a real charger cannot react at once
  always @(posedge aclk) begin
    current <= (want_charge && !battery_good_n) ? 16'h01f4 : -load_ma;
  end
endmodule // charger_model
`default_nettype wire

// File: tb/pack_temp_protect_asserts.sv
// port checks for the pack temperature protection block
`timescale 1ns/1ps
`default_nettype none
`include "pack_temp_map.vh"
module pack_temp_protect_asserts #(
  parameter TICK_CYCLES = 8
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // outputs
  input wire logic        battery_good_n,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] since_change;
  // saturating, so a long quiet spell cannot wrap into a false short gap
  always @(posedge aclk) begin
    if (!aresetn || $changed(battery_good_n)) since_change <= 8'h00;
    else if (since_change != 8'hff) since_change <= since_change + 8'h01;
  end
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write got no response");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read got no data");
  a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:6] != 26'h0
    |=> s_axi_rvalid && s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_write_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr[31:6] != 26'h0 |-> ##[1:2] s_axi_bvalid && s_axi_bresp == `RESP_SLVERR)
    else $error("unmapped write");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
    && !battery_good_n && !irq) else $error("outputs busy after reset");
  a_irq_clear_cause: assert property ($fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt fell without a write");
  a_bgood_pace: assert property ($changed(battery_good_n) |-> since_change >= TICK_CYCLES - 1)
    else $error("battery good moved between ticks");
  c_bgood_rise: cover property ($rose(battery_good_n));
  c_irq_rise: cover property ($rose(irq));
  c_slave_error: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule // pack_temp_protect_asserts
bind pack_temp_protect pack_temp_protect_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_pack_temp_protect_asserts (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .battery_good_n, .irq);
`default_nettype wire

// File: tb/pack_temp_protect_bench.sv
// self-checking bench for the pack temperature protection block
`timescale 1ns/1ps
`default_nettype none
`include "pack_temp_map.vh"
module pack_temp_protect_bench;
  logic        aclk, aresetn, want_charge, battery_good_n, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, got;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] temperature, current, load_ma;
  logic [31:0] rst_val [15] = '{0, 0, 0, 0, 32'h32, 32'h32, 32'h226, 32'h2, 32'h1f4, 32'h258, 32'h2,
                                32'h226, 0, 32'h1c2, 32'h64};
  logic [15:0] temps [6] = '{16'h01c2, 16'h0190, 16'h015e, 16'h0000, 16'h005a, 16'h0064};
  logic [5:0]  out_exp = 6'h1b;
  int          n_errors, comparisons, cycles;
  pack_temp_protect #(.TICK_CYCLES(8)) i_pack_temp_protect (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .temperature, .current, .battery_good_n, .irq);
  charger_model i_charger_model (.aclk, .battery_good_n, .want_charge, .load_ma, .current);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check(name, got, exp);
  endtask
  // one fault direction: window too short, zero delay, real fault, then recovery
  task automatic overheat(input logic [31:0] dly, input logic [15:0] hot, input logic [15:0] rel, input int b);
    wr(dly, 4);
    temperature <= hot;
    idle(12);
    temperature <= 16'h012c;
    idle(64);
    rd("short fault", `REG_STATUS, 0);
    wr(dly, 0);
    temperature <= hot + 16'h0032;
    idle(64);
    rd("zero delay", `REG_STATUS, 0);
    temperature <= 16'h012c;
    wr(dly, 2);
    idle(16);
    temperature <= hot;
    idle(64);
    rd("fault flag", `REG_STATUS, 32'h1 << b);
    check("irq", irq, 1);
    want_charge <= 1'b0;
    load_ma <= 16'h0000;
    temperature <= rel + 16'h000a;
    idle(32);
    rd("held flag", `REG_STATUS, 32'h1 << b);
    temperature <= rel;
    idle(24);
    rd("released flag", `REG_STATUS, 0);
    wr(`REG_INT_STATUS, 32'h1 << b);
    idle(2);
    check("irq", irq, 0);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, want_charge} = 7'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    temperature = 16'h00fa;
    load_ma = 16'h0000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 15; i++) rd("reset value", i * 4, rst_val[i]);
    rd("sampled temperature", `REG_TEMPERATURE, 32'hfa);
    check("read response", resp, `RESP_OKAY);
    wr(32'h40, 1);
    check("unmapped write", resp, `RESP_SLVERR);
    rd("unmapped read", 32'h40, 0);
    check("unmapped read", resp, `RESP_SLVERR);
    wr(`REG_STATUS, 32'hf);
    check("write response", resp, `RESP_OKAY);
    rd("read-only status", `REG_STATUS, 0);
    wr(`REG_INT_MASK, 7);
    want_charge <= 1'b1;
    overheat(`REG_CHG_OH_DELAY, 16'h0226, 16'h01f4, 0);
    load_ma <= 16'h0064;
    overheat(`REG_DSG_OH_DELAY, 16'h0258, 16'h0226, 1);
    // in range and charging before enable, else the first out-of-range tick stops the charger unflagged
    temperature <= 16'h00fa;
    want_charge <= 1'b1;
    idle(16);
    wr(`REG_CONTROL, 1);
    for (int i = 0; i < 6; i++) begin
      temperature <= temps[i];
      idle(24);
      rd("block state", `REG_STATUS, {out_exp[i], out_exp[i], 2'b00});
      check("battery good", battery_good_n, out_exp[i]);
    end
    rd("block event", `REG_INT_STATUS, 4);
    wr(`REG_INT_MASK, 3);
    idle(2);
    check("masked irq", irq, 0);
    wr(`REG_INT_MASK, 7);
    idle(2);
    check("unmasked irq", irq, 1);
    temperature <= 16'h0000;
    idle(24);
    wr(`REG_CONTROL, 0);
    idle(24);
    check("disabled block", battery_good_n, 0);
    wr(`REG_INT_STATUS, 7);
    idle(2);
    check("cleared irq", irq, 0);
    conclude();
  end
endmodule // pack_temp_protect_bench
`default_nettype wire
